/* File: rtl/rtk_pkg.sv */
//------------------------------------------------------------------------------
// Purpose : Constants, register map and BCD helpers for the RTC counter block
// Assumes : 100 MHz CLK, register port driven by the serial bus engine
// Notes   : Counters hold BCD; unused bits of each field read as zero
//------------------------------------------------------------------------------
// Notes on behaviour
// - Month is BCD, units in low four bits, one tens bit, range 1 to 12.
// - Date is BCD, units in low four bits, two tens bits, range 1 to 31.
// - Leap years handled automatically, February ends on the right day.
// - Weekday is a three-bit ring counter, 1 through 7, back to 1.
// - Hours in 24-hour BCD, units in low four bits, two tens bits 0 to 2.
// - Minutes BCD, units in low four bits, three tens bits, range 0 to 59.
// - Seconds BCD, units in low four bits, three tens bits, range 0 to 59.
// - Oscillator stop bit at 1 halts timekeeping; at 0 the clock runs.
// - Calibration sign 1 adds to the timebase, 0 subtracts from it.
package rtk_pkg;

    //--------------------------------------------------------------------------
    // Register offsets
    //--------------------------------------------------------------------------
    localparam logic [7:0] OFS_CALCTL = 8'h08;
    localparam logic [7:0] OFS_SEC    = 8'h09;
    localparam logic [7:0] OFS_MIN    = 8'h0a;
    localparam logic [7:0] OFS_HOUR   = 8'h0b;
    localparam logic [7:0] OFS_WDAY   = 8'h0c;
    localparam logic [7:0] OFS_DATE   = 8'h0d;
    localparam logic [7:0] OFS_MONTH  = 8'h0e;
    localparam logic [7:0] OFS_YEAR   = 8'h0f;

    //--------------------------------------------------------------------------
    // Field layout and masks
    //--------------------------------------------------------------------------
    localparam int         BIT_OSC_STOP = 7;
    localparam int         BIT_CAL_ADD  = 5;
    localparam logic [7:0] MSK_CALCTL   = 8'ha0;
    localparam logic [7:0] MSK_SEC      = 8'h7f;
    localparam logic [7:0] MSK_MIN      = 8'h7f;
    localparam logic [7:0] MSK_HOUR     = 8'h3f;
    localparam logic [7:0] MSK_WDAY     = 8'h07;
    localparam logic [7:0] MSK_DATE     = 8'h3f;
    localparam logic [7:0] MSK_MONTH    = 8'h1f;
    localparam logic [7:0] MSK_YEAR     = 8'hff;

    //--------------------------------------------------------------------------
    // Wrap points and reset values (BCD)
    //--------------------------------------------------------------------------
    localparam logic [7:0] MAX_SEC   = 8'h59;
    localparam logic [7:0] MAX_MIN   = 8'h59;
    localparam logic [7:0] MAX_HOUR  = 8'h23;
    localparam logic [7:0] MAX_WDAY  = 8'h07;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR  = 8'h99;
    localparam logic [7:0] MIN_ZERO  = 8'h00;
    localparam logic [7:0] MIN_ONE   = 8'h01;
    localparam logic [7:0] RST_CALCTL = 8'h00;
    localparam logic [7:0] RST_TIME   = 8'h00;
    localparam logic [7:0] RST_DAY    = 8'h01;
    localparam logic [7:0] RD_NONE    = 8'h00;

    //--------------------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          SECOND_NS      = 1000000000;
    localparam int          SEC_CYCLES     = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [31:0] CAL_TRIM_CYCLES = 32'h0000_0001;

    // Next BCD value of a counter that wraps from hi back to lo
    function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] hi,
                                            input logic [7:0] lo);
        logic [7:0] r;
        r = 8'h00;
        if (v >= hi)
            r = lo;
        else if (v[3:0] >= 4'h9)
            r = {v[7:4] + 4'h1, 4'h0};
        else
            r = {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    // Last day of the month in BCD, with the leap-year rule on the BCD year
    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        logic [7:0] r;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        unique case (mon)
            8'h02:                      r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default:                    r = 8'h31;
        endcase
        return r;
    endfunction

endpackage

/* File: rtl/rtk_tick_if.sv */
//------------------------------------------------------------------------------
// Purpose : Carries the timebase control and one-second tick between modules
// Assumes : Single clock domain
// Notes   : Timebase drives tick, counter core drives stop and sign
//------------------------------------------------------------------------------
`timescale 1ns/1ps
interface rtk_tick_if;
    logic tick;
    logic osc_stop;
    logic cal_add;
    modport timebase (input osc_stop, input cal_add, output tick);
    modport core     (output osc_stop, output cal_add, input tick);
endinterface

/* File: rtl/rtk_timebase.sv */
//------------------------------------------------------------------------------
// Purpose : Divides CLK down to a calibrated one-second tick
// Assumes : Period parameter well above the trim amount
// Notes   : Stopping holds the divider where it is, so restart resumes mid-second
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module rtk_timebase
    import rtk_pkg::*;
#(
    parameter logic [31:0] PERIOD = 32'(SEC_CYCLES)
) (
    input  wire logic       clk,
    input  wire logic       rst,
    rtk_tick_if.timebase    tb
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] last_cnt;
    logic        wrap;
    logic        tick_q;

    // Adding shortens the second, subtracting stretches it
    assign last_cnt = tb.cal_add ? PERIOD - 32'h1 - CAL_TRIM_CYCLES
                                 : PERIOD - 32'h1 + CAL_TRIM_CYCLES;
    assign wrap     = !tb.osc_stop && (cnt_q >= last_cnt);
    assign cnt_d    = tb.osc_stop ? cnt_q : (wrap ? 32'h0 : cnt_q + 32'h1);
    assign tb.tick  = tick_q;

    // Divider and tick pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= wrap;
        end
    end

endmodule

/* File: rtl/rtk_counters.sv */
//------------------------------------------------------------------------------
// Purpose : Timekeeping counters with calibration and control register
// Assumes : Register port is driven by the serial bus engine, one access a cycle
// Notes   : A host write to a counter wins over that counter's own advance
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module rtk_counters
    import rtk_pkg::*;
#(
    parameter logic [31:0] SEC_PERIOD = 32'(SEC_CYCLES)
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    output logic            SEC_TICK
);

    //--------------------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------------------
    logic [7:0] calctl_q;
    logic [7:0] sec_q;
    logic [7:0] min_q;
    logic [7:0] hour_q;
    logic [7:0] wday_q;
    logic [7:0] date_q;
    logic [7:0] month_q;
    logic [7:0] year_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       sec_tick_q;

    rtk_tick_if tick_if ();

    rtk_timebase #(
        .PERIOD (SEC_PERIOD)
    ) u_timebase (
        .clk (CLK),
        .rst (RST),
        .tb  (tick_if)
    );

    //--------------------------------------------------------------------------
    // Control to the timebase
    //--------------------------------------------------------------------------
    assign tick_if.osc_stop = calctl_q[BIT_OSC_STOP];
    assign tick_if.cal_add  = calctl_q[BIT_CAL_ADD];

    //--------------------------------------------------------------------------
    // Carry chain
    //--------------------------------------------------------------------------
    logic       tick;
    logic       c_sec;
    logic       c_min;
    logic       c_hour;
    logic       c_date;
    logic       c_month;
    logic [7:0] last_day;
    logic [7:0] sec_n;
    logic [7:0] min_n;
    logic [7:0] hour_n;
    logic [7:0] wday_n;
    logic [7:0] date_n;
    logic [7:0] month_n;
    logic [7:0] year_n;

    // Each stage advances only when everything below it is at its wrap point
    assign tick     = tick_if.tick;
    assign last_day = month_last(month_q, year_q);
    assign c_sec    = tick && (sec_q >= MAX_SEC);
    assign c_min    = c_sec && (min_q >= MAX_MIN);
    assign c_hour   = c_min && (hour_q >= MAX_HOUR);
    assign c_date   = c_hour && (date_q >= last_day);
    assign c_month  = c_date && (month_q >= MAX_MONTH);

    assign sec_n   = bcd_next(sec_q, MAX_SEC, MIN_ZERO);
    assign min_n   = bcd_next(min_q, MAX_MIN, MIN_ZERO);
    assign hour_n  = bcd_next(hour_q, MAX_HOUR, MIN_ZERO);
    assign date_n  = bcd_next(date_q, last_day, MIN_ONE);
    assign month_n = bcd_next(month_q, MAX_MONTH, MIN_ONE);
    assign year_n  = bcd_next(year_q, MAX_YEAR, MIN_ZERO);
    // Plain ring, not tied to the date; a written 0 steps to 1
    assign wday_n  = (wday_q[2:0] >= MAX_WDAY[2:0] || wday_q[2:0] == 3'h0)
                     ? MIN_ONE : {5'h0, wday_q[2:0] + 3'h1};

    //--------------------------------------------------------------------------
    // Register decode
    //--------------------------------------------------------------------------
    logic we_calctl;
    logic we_sec;
    logic we_min;
    logic we_hour;
    logic we_wday;
    logic we_date;
    logic we_month;
    logic we_year;

    assign we_calctl = REG_WR && (REG_ADDR == OFS_CALCTL);
    assign we_sec    = REG_WR && (REG_ADDR == OFS_SEC);
    assign we_min    = REG_WR && (REG_ADDR == OFS_MIN);
    assign we_hour   = REG_WR && (REG_ADDR == OFS_HOUR);
    assign we_wday   = REG_WR && (REG_ADDR == OFS_WDAY);
    assign we_date   = REG_WR && (REG_ADDR == OFS_DATE);
    assign we_month  = REG_WR && (REG_ADDR == OFS_MONTH);
    assign we_year   = REG_WR && (REG_ADDR == OFS_YEAR);

    //--------------------------------------------------------------------------
    // Next values
    //--------------------------------------------------------------------------
    logic [7:0] calctl_d;
    logic [7:0] sec_d;
    logic [7:0] min_d;
    logic [7:0] hour_d;
    logic [7:0] wday_d;
    logic [7:0] date_d;
    logic [7:0] month_d;
    logic [7:0] year_d;

    // Writes are masked to the field widths so unused bits stay zero
    assign calctl_d = we_calctl ? (REG_WDATA & MSK_CALCTL) : calctl_q;
    assign sec_d    = we_sec   ? (REG_WDATA & MSK_SEC)   : (tick   ? sec_n   : sec_q);
    assign min_d    = we_min   ? (REG_WDATA & MSK_MIN)   : (c_sec  ? min_n   : min_q);
    assign hour_d   = we_hour  ? (REG_WDATA & MSK_HOUR)  : (c_min  ? hour_n  : hour_q);
    assign wday_d   = we_wday  ? (REG_WDATA & MSK_WDAY)  : (c_hour ? wday_n  : wday_q);
    assign date_d   = we_date  ? (REG_WDATA & MSK_DATE)  : (c_hour ? date_n  : date_q);
    assign month_d  = we_month ? (REG_WDATA & MSK_MONTH) : (c_date ? month_n : month_q);
    assign year_d   = we_year  ? (REG_WDATA & MSK_YEAR)  : (c_month ? year_n : year_q);

    //--------------------------------------------------------------------------
    // Counter registers
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            calctl_q <= RST_CALCTL;
            sec_q    <= RST_TIME;
            min_q    <= RST_TIME;
            hour_q   <= RST_TIME;
            wday_q   <= RST_DAY;
            date_q   <= RST_DAY;
            month_q  <= RST_DAY;
            year_q   <= RST_TIME;
        end else begin
            calctl_q <= calctl_d;
            sec_q    <= sec_d;
            min_q    <= min_d;
            hour_q   <= hour_d;
            wday_q   <= wday_d;
            date_q   <= date_d;
            month_q  <= month_d;
            year_q   <= year_d;
        end
    end

    //--------------------------------------------------------------------------
    // Read path
    //--------------------------------------------------------------------------
    logic [7:0] rd_mux;

    // Unmapped offsets read as zero rather than holding the last value
    assign rd_mux = (REG_ADDR == OFS_CALCTL) ? calctl_q :
                    (REG_ADDR == OFS_SEC)    ? sec_q    :
                    (REG_ADDR == OFS_MIN)    ? min_q    :
                    (REG_ADDR == OFS_HOUR)   ? hour_q   :
                    (REG_ADDR == OFS_WDAY)   ? wday_q   :
                    (REG_ADDR == OFS_DATE)   ? date_q   :
                    (REG_ADDR == OFS_MONTH)  ? month_q  :
                    (REG_ADDR == OFS_YEAR)   ? year_q   : RD_NONE;

    // Registered outputs; read data holds until the next read
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q    <= RD_NONE;
            rvalid_q   <= 1'b0;
            sec_tick_q <= 1'b0;
        end else begin
            rdata_q    <= REG_RD ? rd_mux : rdata_q;
            rvalid_q   <= REG_RD;
            sec_tick_q <= tick;
        end
    end

    assign REG_RDATA  = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign SEC_TICK   = sec_tick_q;

endmodule

/* File: tb/rtk_counters_checker.sv */
// Purpose : Assertions on the register port and second tick of the counter block
// Assumes : Host keeps written time fields within their BCD ranges
// Notes   : Tick spacing is only judged over intervals with no control write
`timescale 1ns/1ps
module rtk_counters_checker
    import rtk_pkg::*;
#(
    parameter logic [31:0] SEC_PERIOD = 32'(SEC_CYCLES)
) (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       SEC_TICK
);
    logic [7:0]  addr_q;
    logic        stop_q;
    logic        add_q;
    logic        chg_q;
    logic        seen_q;
    logic [31:0] gap_q;
    wire logic   cal_wr = REG_WR && REG_ADDR == OFS_CALCTL;
    // In range with a legal units digit
    function automatic logic ok(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return v >= lo && v <= hi && v[3:0] <= 4'h9;
    endfunction
    // Shadows of read address and control bits; gap counts cycles between ticks
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            addr_q <= 8'h00;
            stop_q <= 1'b0;
            add_q  <= 1'b0;
            chg_q  <= 1'b0;
            seen_q <= 1'b0;
            gap_q  <= 32'h0;
        end else begin
            addr_q <= REG_RD ? REG_ADDR : addr_q;
            stop_q <= cal_wr ? REG_WDATA[7] : stop_q;
            add_q  <= cal_wr ? REG_WDATA[5] : add_q;
            chg_q  <= cal_wr || (chg_q && !SEC_TICK);
            seen_q <= seen_q || SEC_TICK;
            gap_q  <= SEC_TICK ? 32'h1 : gap_q + 32'h1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    AST_RD_ANSWER:
    assert property (REG_RD |=> REG_RVALID ##1 (REG_RVALID == $past(REG_RD))) else $error("read answer late");
    AST_SEC_RANGE:
    assert property (REG_RVALID && addr_q == OFS_SEC |-> ok(REG_RDATA, 8'h00, 8'h59)) else $error("seconds bad");
    AST_MIN_RANGE:
    assert property (REG_RVALID && addr_q == OFS_MIN |-> ok(REG_RDATA, 8'h00, 8'h59)) else $error("minutes bad");
    AST_HOUR_RANGE:
    assert property (REG_RVALID && addr_q == OFS_HOUR |-> ok(REG_RDATA, 8'h00, 8'h23)) else $error("hours bad");
    AST_WDAY_RANGE:
    assert property (REG_RVALID && addr_q == OFS_WDAY |-> ok(REG_RDATA, 8'h01, 8'h07)) else $error("weekday bad");
    AST_DATE_RANGE:
    assert property (REG_RVALID && addr_q == OFS_DATE |-> ok(REG_RDATA, 8'h01, 8'h31)) else $error("date bad");
    AST_MONTH_RANGE:
    assert property (REG_RVALID && addr_q == OFS_MONTH |-> ok(REG_RDATA, 8'h01, 8'h12)) else $error("month bad");
    AST_STOP_HALTS:
    assert property (stop_q && $past(stop_q) && $past(stop_q, 2) |-> !SEC_TICK) else $error("tick while stopped");
    AST_TICK_GAP:
    assert property (SEC_TICK && seen_q && !chg_q |-> gap_q == (add_q ? SEC_PERIOD - 1 : SEC_PERIOD + 1))
        else $error("tick spacing wrong");
endmodule
bind rtk_counters rtk_counters_checker #(.SEC_PERIOD(SEC_PERIOD)) i_rtk_counters_checker (.CLK(CLK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .SEC_TICK(SEC_TICK));

/* File: tb/rtk_host_model.sv */
// Purpose : Host model driving the register port in place of the serial engine
// Assumes : One access at a time, strobes changed at the falling edge
// Notes   : Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module rtk_host_model
    import rtk_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // One-cycle strobe, then address and data are inverted so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // Data is taken when the valid pulse shows, one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    // Halt timekeeping before loading a time, as a host does for storage
    task automatic park();
        wr(OFS_CALCTL, 8'h80);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Purpose : Self-checking bench for the timekeeping counters
// Assumes : Short second period so many rollovers fit in one run
// Notes   : Each time is loaded while halted, so no tick races the writes
`timescale 1ns/1ps
module tb_top;
    import rtk_pkg::*;
    typedef logic [7:0] rtk_tv_t [7];
    localparam logic [31:0] PER     = 32'd32;
    localparam logic [7:0]  OFS [7] = '{OFS_SEC, OFS_MIN, OFS_HOUR, OFS_WDAY, OFS_DATE, OFS_MONTH, OFS_YEAR};
    logic       clk;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_wr;
    logic       reg_rd;
    logic       reg_rvalid;
    logic       sec_tick;
    logic [7:0] d;
    rtk_tv_t    tv;
    rtk_tv_t    e;
    int         n;
    int         fail_count  = 0;
    int         check_count = 0;
    int         cycles      = 0;
    rtk_counters #(.SEC_PERIOD(PER)) i_rtk_counters (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .SEC_TICK(sec_tick));
    rtk_host_model i_rtk_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [7:0] inc(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
        return (v == hi) ? lo : (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    // Month length; leap test done on the decimal year
    function automatic logic [7:0] mlast(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02)
            return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
        return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
    endfunction
    function automatic logic [7:0] rb(input int lo, input int hi);
        int v;
        v = $urandom_range(hi, lo);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    // Expected fields after one second, carries cascaded
    function automatic rtk_tv_t step(input rtk_tv_t v);
        rtk_tv_t r;
        r = v;
        r[0] = inc(v[0], 8'h59, 8'h00);
        if (v[0] == 8'h59)
            r[1] = inc(v[1], 8'h59, 8'h00);
        if (v[0] == 8'h59 && v[1] == 8'h59)
            r[2] = inc(v[2], 8'h23, 8'h00);
        if (v[0] == 8'h59 && v[1] == 8'h59 && v[2] == 8'h23) begin
            r[3] = inc(v[3], 8'h07, 8'h01);
            r[4] = inc(v[4], mlast(v[5], v[6]), 8'h01);
            if (v[4] == mlast(v[5], v[6])) begin
                r[5] = inc(v[5], 8'h12, 8'h01);
                if (v[5] == 8'h12)
                    r[6] = inc(v[6], 8'h99, 8'h00);
            end
        end
        return r;
    endfunction
    // Bounded wait for the tick pulse, seen at a falling edge
    task automatic wait_tick();
        n = 0;
        while (sec_tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        void'($urandom(34));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        // Reset values, masked bits and unmapped space
        e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        for (int i = 0; i < 7; i++) begin
            i_rtk_host_model.rd(OFS[i], d);
            chk(d, e[i]);
        end
        i_rtk_host_model.wr(8'h10, 8'h55);
        i_rtk_host_model.rd(8'h10, d);
        chk(d, 8'h00);
        i_rtk_host_model.wr(OFS_WDAY, 8'hff);
        i_rtk_host_model.rd(OFS_WDAY, d);
        chk(d, 8'h07);
        i_rtk_host_model.wr(OFS_CALCTL, 8'hff);
        i_rtk_host_model.rd(OFS_CALCTL, d);
        chk(d, 8'ha0);
        $display("test reset_map done");
        // Halted: no tick and seconds frozen over three periods
        i_rtk_host_model.rd(OFS_SEC, d);
        n = 0;
        for (int i = 0; i < 3 * PER; i++) begin
            @(negedge clk);
            n += (sec_tick === 1'b1);
        end
        chk(8'(n), 8'h00);
        i_rtk_host_model.rd(OFS_SEC, e[0]);
        chk(e[0], d);
        $display("test stop done");
        // Tick spacing for both calibration signs
        for (int s = 0; s < 2; s++) begin
            i_rtk_host_model.wr(OFS_CALCTL, s ? 8'h00 : 8'h20);
            wait_tick();
            @(negedge clk);
            wait_tick();
            chk(8'(n + 1), s ? 8'(PER + 1) : 8'(PER - 1));
        end
        $display("test calibration done");
        // Random times, most at full rollover, month ends and February favoured
        for (int k = 0; k < 40; k++) begin
            tv[6] = rb(0, 99);
            tv[5] = (k % 3 == 1) ? 8'h02 : (k % 5 == 4) ? 8'h12 : rb(1, 12);
            tv[4] = (k % 2 == 0) ? mlast(tv[5], tv[6]) : rb(1, 28);
            tv[3] = rb(1, 7);
            for (int i = 0; i < 3; i++)
                tv[i] = (k % 4 != 3) ? (i == 2 ? 8'h23 : 8'h59) : rb(0, i == 2 ? 23 : 59);
            i_rtk_host_model.park();
            for (int i = 0; i < 7; i++)
                i_rtk_host_model.wr(OFS[i], tv[i]);
            i_rtk_host_model.wr(OFS_CALCTL, 8'h00);
            wait_tick();
            i_rtk_host_model.park();
            e = step(tv);
            for (int i = 0; i < 7; i++) begin
                i_rtk_host_model.rd(OFS[i], d);
                chk(d, e[i]);
            end
        end
        $display("test rollover done");
        test_done();
    end
endmodule
